// ### pkg/nvm_prot_cfg.svh
// Address map, password format, reset values and sequencing constants of the region protection.
`ifndef NVM_PROT_CFG_SVH
`define NVM_PROT_CFG_SVH
`define ROM_LO         32'h0000_0000
`define ROM_HI         32'h0000_5FFF
`define CBSL_LO        32'h1100_0000
`define CBSL_HI        32'h1100_0FFF
`define LIN_LO         32'h1100_1000
`define LIN_HI         32'h1100_DFFF
`define NONLIN_LO      32'h1100_E000
`define NONLIN_HI      32'h1100_FFFF
`define RAM_LO         32'h1800_0000
`define RAM_HI         32'h1800_0FFF
`define PW_NONE        32'h0000_0000
`define PW_ERASED      32'hFFFF_FFFF
`define PW_RD_BIT      31
`define PW_WR_BIT      30
`define RESET_VECTOR   32'h1100_0004
`define PROT_RST       6'h3F
`define PW_LAST        2'h2
`define CBSL_IDX       2'h0
`define LIN_IDX        2'h1
`define NONLIN_IDX     2'h2
`endif

// ### pkg/nvm_prot_pkg.sv
// Types and address decode shared by the region protection design.
`include "nvm_prot_cfg.svh"
package nvm_prot_pkg;
   typedef enum logic [2:0] {rg_rom, rg_cbsl, rg_lin, rg_nonlin, rg_ram, rg_other} region_e;
   typedef enum logic [1:0] {op_set_pw, op_del_pw, op_chg_prot} fw_op_e;
   // Bit index 0 is the customer boot region, 1 the linear region, 2 the non-linear region.
   typedef struct packed {
      logic [2:0] rd;
      logic [2:0] wr;
   } prot_s;
   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        debug;
      logic [31:0] src_addr;
      logic [31:0] addr;
   } mem_acc_s;
   typedef struct packed {
      logic        valid;
      fw_op_e      op;
      logic [1:0]  region;
      logic [31:0] pw;
      logic        rd;
      logic        wr;
   } fw_cmd_s;

   function automatic region_e region_of(input logic [31:0] a);
      if (a <= `ROM_HI) begin
         region_of = rg_rom;
      end else if (a >= `CBSL_LO && a <= `CBSL_HI) begin
         region_of = rg_cbsl;
      end else if (a >= `LIN_LO && a <= `LIN_HI) begin
         region_of = rg_lin;
      end else if (a >= `NONLIN_LO && a <= `NONLIN_HI) begin
         region_of = rg_nonlin;
      end else if (a >= `RAM_LO && a <= `RAM_HI) begin
         region_of = rg_ram;
      end else begin
         region_of = rg_other;
      end
   endfunction

   function automatic logic [1:0] flash_idx(input region_e r);
      if (r == rg_lin) begin
         flash_idx = `LIN_IDX;
      end else if (r == rg_nonlin) begin
         flash_idx = `NONLIN_IDX;
      end else begin
         flash_idx = `CBSL_IDX;
      end
   endfunction

   function automatic logic pw_valid(input logic [31:0] p);
      pw_valid = (p != `PW_NONE) && (p != `PW_ERASED);
   endfunction
endpackage

// ### design/pw_store.sv
// Non-volatile password store with one word per protectable flash region.
`timescale 1ns/1ns
`default_nettype none
`include "nvm_prot_cfg.svh"
module pw_store (
   input  wire logic        clock,
   input  wire logic        por_n,
   input  wire logic [1:0]  rd_addr,
   output logic      [31:0] rd_data_ff,
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_addr,
   input  wire logic [31:0] wr_data
);
   logic [31:0] word_ff [0:2];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gen_word
         always_ff @(posedge clock) begin
            if (!por_n) begin
               word_ff[g] <= `PW_ERASED;
            end else if (wr_en && wr_addr == 2'(g)) begin
               word_ff[g] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!por_n) begin
         rd_data_ff <= `PW_ERASED;
      end else if (rd_addr <= `PW_LAST) begin
         rd_data_ff <= word_ff[rd_addr];
      end else begin
         rd_data_ff <= `PW_ERASED;
      end
   end
endmodule
`default_nettype wire

// ### design/nvm_region_protection.sv
// Region protection checker, protection state register, password handling and debug lock.
`timescale 1ns/1ns
`default_nettype none
`include "nvm_prot_cfg.svh"
module nvm_region_protection
   import nvm_prot_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic        bootstrap_loader_mode,
   input  wire mem_acc_s    acc_in,
   input  wire logic [31:0] acc_rdata,
   output logic             acc_grant_ff,
   output logic             acc_block_ff,
   output logic      [31:0] acc_rdata_ff,
   input  wire logic        nvm_cmd_valid,
   input  wire logic [31:0] nvm_cmd_addr,
   output logic             nvm_cmd_block_ff,
   input  wire logic        fw_pe_valid,
   input  wire logic [31:0] fw_pe_addr,
   output logic             fw_pe_go_ff,
   output logic             fw_pe_err_ff,
   input  wire logic        dir_wr_valid,
   input  wire logic [31:0] dir_wr_src_addr,
   input  wire prot_s       dir_wr_data,
   output logic             dir_wr_ack_ff,
   output logic             dir_wr_err_ff,
   input  wire fw_cmd_s     fw_cmd,
   output logic             fw_busy_ff,
   output logic             fw_done_ff,
   output logic             fw_err_ff,
   output logic             erase_all_ff,
   input  wire logic [31:0] dbg_pc,
   input  wire logic        dbg_cmd_valid,
   output logic             dbg_cmd_ack_ff,
   output logic             dbg_connect_ok_ff,
   output logic             download_lock_ff,
   output logic      [31:0] boot_addr_ff,
   output logic             boot_done_ff,
   output prot_s            region_protect_state_reg
);
   typedef enum logic [2:0] {st_ld_rd, st_ld_ev, st_idle, st_cmd_ev, st_wipe} state_e;

   state_e      state_ff;
   state_e      nxt_state;
   logic [1:0]  ld_idx_ff;
   logic [1:0]  wipe_idx_ff;
   fw_cmd_s     cmd_ff;
   prot_s       prot_ff;
   logic        pw_rd_inst_ff;
   logic [1:0]  pw_rd_addr;
   logic [31:0] pw_rd_data;
   logic        pw_we;
   logic [1:0]  pw_waddr;
   logic [31:0] pw_wdata;
   logic        installed;
   logic        match;
   logic        cmd_ok;
   logic        chg_bits;
   logic        go_wipe;
   region_e     src_rg;
   region_e     dw_rg;
   region_e     tgt_rg;
   logic        rd_ok;
   logic        rd_pending;
   logic        dir_ok;
   logic        dbg_hold;

   pw_store u_pw_store (
      .clock      (clock),
      .por_n      (por_n),
      .rd_addr    (pw_rd_addr),
      .rd_data_ff (pw_rd_data),
      .wr_en      (pw_we),
      .wr_addr    (pw_waddr),
      .wr_data    (pw_wdata)
   );

   assign region_protect_state_reg = prot_ff;
   assign installed = pw_valid(pw_rd_data);
   assign match     = pw_rd_data == cmd_ff.pw;
   assign pw_rd_addr = (state_ff == st_idle) ? fw_cmd.region : ld_idx_ff;

   // Firmware password and protection routines.
   always_comb begin
      pw_we    = 1'b0;
      pw_waddr = cmd_ff.region;
      pw_wdata = `PW_ERASED;
      cmd_ok   = 1'b0;
      chg_bits = 1'b0;
      go_wipe  = 1'b0;
      if (state_ff == st_cmd_ev && cmd_ff.region <= `PW_LAST) begin
         unique case (cmd_ff.op)
            op_set_pw: begin
               if (!installed && pw_valid(cmd_ff.pw)) begin
                  pw_we    = 1'b1;
                  pw_wdata = cmd_ff.pw;
                  cmd_ok   = 1'b1;
               end
            end
            op_del_pw: begin
               if (installed && match) begin
                  pw_we  = 1'b1;
                  cmd_ok = 1'b1;
               end else if (installed) begin
                  go_wipe = 1'b1;
               end
            end
            op_chg_prot: begin
               if (!installed || match) begin
                  chg_bits = 1'b1;
                  cmd_ok   = 1'b1;
               end else begin
                  go_wipe = 1'b1;
               end
            end
            default: begin
               cmd_ok = 1'b0;
            end
         endcase
      end else if (state_ff == st_wipe) begin
         pw_we    = 1'b1;
         pw_waddr = wipe_idx_ff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_ld_rd: nxt_state = st_ld_ev;
         st_ld_ev: nxt_state = (ld_idx_ff == `PW_LAST) ? st_idle : st_ld_rd;
         st_idle: nxt_state = fw_cmd.valid ? st_cmd_ev : st_idle;
         st_cmd_ev: nxt_state = go_wipe ? st_wipe : st_idle;
         st_wipe: nxt_state = (wipe_idx_ff == `PW_LAST) ? st_idle : st_wipe;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_ff <= st_ld_rd;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ld_idx_ff   <= 2'h0;
         wipe_idx_ff <= 2'h0;
      end else begin
         if (state_ff == st_ld_ev) begin
            ld_idx_ff <= ld_idx_ff + 2'h1;
         end
         if (state_ff == st_wipe) begin
            wipe_idx_ff <= (wipe_idx_ff == `PW_LAST) ? 2'h0 : wipe_idx_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd_ff <= '0;
      end else if (state_ff == st_idle && fw_cmd.valid) begin
         cmd_ff <= fw_cmd;
      end
   end

   // Direct write gate: user boot, source in boot ROM, or in customer boot or linear flash while no read password is installed.
   always_comb begin
      dw_rg  = region_of(dir_wr_src_addr);
      dir_ok = boot_done_ff && !bootstrap_loader_mode && (dw_rg == rg_rom ||
               ((dw_rg == rg_cbsl || dw_rg == rg_lin) && !pw_rd_inst_ff));
   end

   // Protection state register, reloaded from passwords at every reset.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prot_ff <= `PROT_RST;
      end else if (state_ff == st_ld_ev) begin
         prot_ff.rd[ld_idx_ff] <= installed && pw_rd_data[`PW_RD_BIT];
         prot_ff.wr[ld_idx_ff] <= installed && pw_rd_data[`PW_WR_BIT];
      end else if (chg_bits) begin
         prot_ff.rd[cmd_ff.region] <= cmd_ff.rd;
         prot_ff.wr[cmd_ff.region] <= cmd_ff.wr;
      end else if (dir_wr_valid && dir_ok && state_ff == st_idle) begin
         prot_ff.rd[2:1] <= dir_wr_data.rd[2:1];
         prot_ff.wr[2:1] <= dir_wr_data.wr[2:1];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pw_rd_inst_ff <= 1'b0;
         boot_done_ff  <= 1'b0;
      end else if (state_ff == st_ld_ev) begin
         pw_rd_inst_ff <= pw_rd_inst_ff | (installed & pw_rd_data[`PW_RD_BIT]);
         boot_done_ff  <= ld_idx_ff == `PW_LAST;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dir_wr_ack_ff <= 1'b0;
         dir_wr_err_ff <= 1'b0;
      end else begin
         dir_wr_ack_ff <= dir_wr_valid && dir_ok && state_ff == st_idle && !chg_bits;
         dir_wr_err_ff <= dir_wr_valid && !(dir_ok && state_ff == st_idle);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fw_busy_ff   <= 1'b1;
         fw_done_ff   <= 1'b0;
         fw_err_ff    <= 1'b0;
         erase_all_ff <= 1'b0;
      end else begin
         fw_busy_ff   <= nxt_state != st_idle;
         fw_done_ff   <= state_ff == st_cmd_ev;
         fw_err_ff    <= state_ff == st_cmd_ev && !cmd_ok;
         erase_all_ff <= go_wipe;
      end
   end

   // Data access check.
   always_comb begin
      src_rg = rg_other;
      tgt_rg = region_of(acc_in.addr);
      rd_ok  = 1'b1;
      if (!acc_in.fetch) begin
         src_rg = region_of(acc_in.src_addr);
         unique case (tgt_rg)
            rg_rom: rd_ok = !acc_in.debug && src_rg == rg_rom;
            rg_cbsl, rg_lin, rg_nonlin: begin
               rd_ok = !prot_ff.rd[flash_idx(tgt_rg)] || (!acc_in.debug &&
                       ((src_rg == tgt_rg && tgt_rg != rg_nonlin) ||
                        (tgt_rg == rg_nonlin && (src_rg == rg_cbsl || src_rg == rg_lin))));
            end
            rg_ram, rg_other: rd_ok = 1'b1;
         endcase
      end
   end

   assign rd_pending = acc_in.debug && pw_rd_inst_ff;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_grant_ff <= 1'b0;
         acc_block_ff <= 1'b0;
         acc_rdata_ff <= 32'h0000_0000;
      end else begin
         acc_grant_ff <= acc_in.valid && !rd_pending && rd_ok;
         acc_block_ff <= acc_in.valid && !rd_pending && !rd_ok;
         acc_rdata_ff <= (acc_in.valid && !rd_pending && rd_ok) ? acc_rdata : 32'h0000_0000;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         nvm_cmd_block_ff <= 1'b0;
         fw_pe_go_ff      <= 1'b0;
         fw_pe_err_ff     <= 1'b0;
      end else begin
         nvm_cmd_block_ff <= nvm_cmd_valid && region_of(nvm_cmd_addr) inside
                             {rg_cbsl, rg_lin, rg_nonlin} &&
                             prot_ff.wr[flash_idx(region_of(nvm_cmd_addr))];
         fw_pe_go_ff  <= fw_pe_valid && !(region_of(fw_pe_addr) inside
                         {rg_cbsl, rg_lin, rg_nonlin} &&
                         prot_ff.wr[flash_idx(region_of(fw_pe_addr))]);
         fw_pe_err_ff <= fw_pe_valid && region_of(fw_pe_addr) inside
                         {rg_cbsl, rg_lin, rg_nonlin} &&
                         prot_ff.wr[flash_idx(region_of(fw_pe_addr))];
      end
   end

   // Debug and boot lockout.
   assign dbg_hold = region_of(dbg_pc) == rg_rom || pw_rd_inst_ff;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dbg_cmd_ack_ff    <= 1'b0;
         dbg_connect_ok_ff <= 1'b0;
         download_lock_ff  <= 1'b1;
         boot_addr_ff      <= `RESET_VECTOR;
      end else begin
         dbg_cmd_ack_ff    <= dbg_cmd_valid && boot_done_ff && !dbg_hold;
         dbg_connect_ok_ff <= boot_done_ff && !pw_rd_inst_ff;
         download_lock_ff  <= !boot_done_ff || pw_rd_inst_ff;
         boot_addr_ff      <= `RESET_VECTOR;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_mismatch;
      state_ff == st_cmd_ev && go_wipe;
   endsequence
   sequence s_wipe_run;
      erase_all_ff && state_ff == st_wipe ##2 state_ff == st_wipe;
   endsequence

   a_nonlin_wr_block: assert property (nvm_cmd_valid && prot_ff.wr[2] &&
      region_of(nvm_cmd_addr) == rg_nonlin |=> nvm_cmd_block_ff)
      else $error("write to protected non-linear region not refused");
   a_nonlin_rd_block: assert property (acc_in.valid && !acc_in.fetch && !acc_in.debug &&
      prot_ff.rd[2] && region_of(acc_in.addr) == rg_nonlin &&
      region_of(acc_in.src_addr) inside {rg_rom, rg_ram, rg_nonlin} |=> acc_block_ff)
      else $error("protected non-linear read not blocked");
   a_debug_no_grant: assert property (acc_in.valid && acc_in.debug && !acc_in.fetch &&
      prot_ff.rd[2] && region_of(acc_in.addr) == rg_nonlin |=> !acc_grant_ff)
      else $error("debugger read of protected region granted");
   a_fetch_free: assert property (acc_in.valid && acc_in.fetch && !acc_in.debug |=>
      acc_grant_ff && !acc_block_ff)
      else $error("instruction fetch was blocked");
   a_blocked_zero: assert property (acc_block_ff |-> acc_rdata_ff == 32'h0000_0000)
      else $error("blocked read returned data");
   a_cbsl_direct: assert property (dir_wr_valid && state_ff == st_idle |=>
      prot_ff.rd[0] == $past(prot_ff.rd[0]) && prot_ff.wr[0] == $past(prot_ff.wr[0]))
      else $error("direct write changed customer boot protection");
   a_boot_load: assert property (!boot_done_ff |-> ##[1:7] boot_done_ff)
      else $error("startup password load too slow");
   a_mismatch_wipe: assert property (s_mismatch |=> s_wipe_run ##1 state_ff == st_idle)
      else $error("password mismatch did not wipe all regions");
   a_dbg_rom_hold: assert property (dbg_cmd_valid && region_of(dbg_pc) == rg_rom |=>
      !dbg_cmd_ack_ff)
      else $error("debug command acted inside boot ROM");
   a_pe_error: assert property (fw_pe_valid && region_of(fw_pe_addr) == rg_lin &&
      prot_ff.wr[1] |=> fw_pe_err_ff && !fw_pe_go_ff)
      else $error("program on write-protected region not refused");
endmodule
`default_nettype wire

// ### verif/core_partner.sv
// Core side model: memory data source for accesses and a debug probe with a command timeout.
`timescale 1ns/1ns
`default_nettype none
module core_partner
   import nvm_prot_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire mem_acc_s    acc_in,
   output logic      [31:0] acc_rdata,
   input  wire logic        dbg_req,
   input  wire logic        dbg_cmd_ack_ff,
   output logic             dbg_cmd_valid,
   output logic             dbg_timeout
);
   logic [31:0] churn_ff;
   logic [3:0]  wait_ff;
   // Outside an access the data lines show a changing pattern, never the last word.
   assign acc_rdata = acc_in.valid ? (acc_in.addr ^ 32'h5A5A_A5A5) : churn_ff;
   always_ff @(posedge clock) begin
      churn_ff <= rst_n ? churn_ff + 32'h0001_3579 : 32'h0000_0000;
   end
   // The probe holds its command until it is executed or gives up after eight cycles.
   always_ff @(posedge clock) begin
      dbg_timeout <= 1'b0;
      if (!rst_n) begin
         dbg_cmd_valid <= 1'b0;
         wait_ff <= 4'h0;
      end else if (dbg_req) begin
         dbg_cmd_valid <= 1'b1;
         wait_ff <= 4'h0;
      end else if (dbg_cmd_valid && (dbg_cmd_ack_ff || wait_ff == 4'h8)) begin
         dbg_cmd_valid <= 1'b0;
         dbg_timeout <= !dbg_cmd_ack_ff;
      end else if (dbg_cmd_valid) begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench of the region protection: accesses, commands, passwords and debug lock.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import nvm_prot_pkg::*;
;
   localparam logic [31:0] ROM = 32'h0000_0100, CB = 32'h1100_0100, LN = 32'h1100_2000;
   localparam logic [31:0] NL = 32'h1100_E100, RAM = 32'h1800_0100;
   logic        clock, rst_n, por_n, loader, dbg_req, nvm_v, pe_v, dw_v, dbg_valid, dbg_to;
   logic        grant, block, nvm_blk, pe_go, pe_err, dw_ack, dw_err, busy, done, ferr, wipe;
   logic        ack, conn, dl_lock, bdone;
   logic [31:0] acc_rd, nvm_a, pe_a, dw_src, pc, rdata, baddr;
   mem_acc_s    acc;
   fw_cmd_s     cmd;
   prot_s       dw_data, prot;
   int          n_fail = 0;
   int          num_checks = 0;

   nvm_region_protection DUT (
      .clock(clock), .rst_n(rst_n), .por_n(por_n), .bootstrap_loader_mode(loader),
      .acc_in(acc), .acc_rdata(acc_rd), .acc_grant_ff(grant), .acc_block_ff(block),
      .acc_rdata_ff(rdata), .nvm_cmd_valid(nvm_v), .nvm_cmd_addr(nvm_a),
      .nvm_cmd_block_ff(nvm_blk), .fw_pe_valid(pe_v), .fw_pe_addr(pe_a), .fw_pe_go_ff(pe_go),
      .fw_pe_err_ff(pe_err), .dir_wr_valid(dw_v), .dir_wr_src_addr(dw_src),
      .dir_wr_data(dw_data), .dir_wr_ack_ff(dw_ack), .dir_wr_err_ff(dw_err), .fw_cmd(cmd),
      .fw_busy_ff(busy), .fw_done_ff(done), .fw_err_ff(ferr), .erase_all_ff(wipe),
      .dbg_pc(pc), .dbg_cmd_valid(dbg_valid), .dbg_cmd_ack_ff(ack),
      .dbg_connect_ok_ff(conn), .download_lock_ff(dl_lock), .boot_addr_ff(baddr),
      .boot_done_ff(bdone), .region_protect_state_reg(prot));
   core_partner core (
      .clock(clock), .rst_n(rst_n), .acc_in(acc), .acc_rdata(acc_rd), .dbg_req(dbg_req),
      .dbg_cmd_ack_ff(ack), .dbg_cmd_valid(dbg_valid), .dbg_timeout(dbg_to));

   task automatic test_done();
      if (n_fail == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
   endtask
   task automatic chk_prot(input logic [5:0] exp);
      chk_word(32'(prot), 32'(exp), "protection state");
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      cyc(2);
      chk_prot(6'h3F);
      rst_n = 1'b1;
      for (int i = 0; i < 20 && !bdone; i++) begin
         cyc(1);
      end
      cyc(1);
      chk_bit(bdone, 1'b1, "startup done");
      chk_word(baddr, 32'h1100_0004, "boot vector");
   endtask
   task automatic rd(input logic [31:0] src, a, input logic dbg, fch, g, b);
      acc = '{1'b1, fch, dbg, src, a};
      cyc(1);
      acc.valid = 1'b0;
      chk_bit(grant, g, "grant");
      chk_bit(block, b, "block");
      chk_word(rdata, g ? (a ^ 32'h5A5A_A5A5) : 32'h0000_0000, "read data");
      cyc(1);
   endtask
   task automatic wr_chk(input logic [31:0] a, input logic p);
      nvm_a = a;
      pe_a = a;
      nvm_v = 1'b1;
      pe_v = 1'b1;
      cyc(1);
      nvm_v = 1'b0;
      pe_v = 1'b0;
      chk_bit(nvm_blk, p, "command refused");
      chk_bit(pe_err, p, "routine error");
      chk_bit(pe_go, !p, "routine run");
      cyc(1);
   endtask
   task automatic dirw(input logic [31:0] src, input logic [2:0] rdv, wrv, input logic ok);
      dw_src = src;
      dw_data = '{rdv, wrv};
      dw_v = 1'b1;
      cyc(1);
      dw_v = 1'b0;
      chk_bit(dw_ack, ok, "direct write ack");
      chk_bit(dw_err, !ok, "direct write error");
      cyc(1);
   endtask
   task automatic api(input fw_op_e op, input logic [1:0] r, input logic [31:0] pw,
                      input logic rdv, wrv, e, w);
      logic seen;
      seen = 1'b0;
      cmd = '{1'b1, op, r, pw, rdv, wrv};
      cyc(1);
      cmd.valid = 1'b0;
      for (int i = 0; i < 8 && !done; i++) begin
         seen |= wipe;
         cyc(1);
      end
      seen |= wipe;
      chk_bit(done, 1'b1, "routine done");
      chk_bit(ferr, e, "routine error");
      chk_bit(seen, w, "erase all");
      for (int i = 0; i < 8 && busy; i++) begin
         cyc(1);
      end
   endtask
   task automatic dbg(input logic [31:0] at, input logic exp);
      logic seen;
      seen = 1'b0;
      pc = at;
      dbg_req = 1'b1;
      cyc(1);
      dbg_req = 1'b0;
      for (int i = 0; i < 14 && (dbg_valid || i == 0); i++) begin
         seen |= ack;
         cyc(1);
      end
      chk_bit(seen, exp, "debug executed");
      chk_bit(dbg_to, !exp, "probe timeout");
      cyc(2);
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      #500_000;
      n_fail++;
      test_done();
   end
   initial begin
      {rst_n, por_n, loader, dbg_req, nvm_v, pe_v, dw_v} = '0;
      acc = '0;
      cmd = '0;
      dw_data = '0;
      {nvm_a, pe_a, dw_src} = '0;
      pc = RAM;
      cyc(20);
      por_n = 1'b1;
      do_reset();
      chk_prot(6'h00);
      chk_bit(dl_lock, 1'b0, "download lock");
      chk_bit(conn, 1'b1, "debug connect");
      rd(RAM, ROM, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(ROM, ROM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(RAM, ROM, 1'b1, 1'b0, 1'b0, 1'b1);
      rd(RAM, NL, 1'b1, 1'b0, 1'b1, 1'b0);
      dbg(ROM, 1'b0);
      dbg(RAM, 1'b1);
      loader = 1'b1;
      dirw(ROM, 3'b100, 3'b100, 1'b0);
      loader = 1'b0;
      dirw(ROM, 3'b111, 3'b111, 1'b1);
      chk_prot(6'h36);
      rd(RAM, NL, 1'b1, 1'b0, 1'b0, 1'b1);
      rd(NL, NL, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(RAM, NL, 1'b0, 1'b1, 1'b1, 1'b0);
      wr_chk(NL, 1'b1);
      wr_chk(CB, 1'b0);
      do_reset();
      chk_prot(6'h00);
      api(op_set_pw, 2'h0, 32'h8000_0011, 1'b0, 1'b0, 1'b0, 1'b0);
      api(op_set_pw, 2'h1, 32'hC000_0022, 1'b0, 1'b0, 1'b0, 1'b0);
      api(op_set_pw, 2'h2, 32'hC000_0033, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_prot(6'h00);
      do_reset();
      chk_prot(6'h3E);
      chk_bit(dl_lock, 1'b1, "download lock");
      chk_bit(conn, 1'b0, "debug connect");
      rd(NL, RAM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(NL, NL, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(RAM, RAM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(RAM, NL, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(ROM, ROM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(ROM, RAM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(ROM, NL, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(LN, CB, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(CB, CB, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(CB, NL, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(CB, RAM, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(LN, LN, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(LN, NL, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(ROM, NL, 1'b0, 1'b1, 1'b1, 1'b0);
      rd(RAM, NL, 1'b1, 1'b0, 1'b0, 1'b0);
      dbg(RAM, 1'b0);
      dirw(LN, 3'b000, 3'b000, 1'b0);
      dirw(ROM, 3'b000, 3'b000, 1'b1);
      chk_prot(6'h08);
      wr_chk(NL, 1'b0);
      api(op_chg_prot, 2'h1, 32'hC000_0022, 1'b0, 1'b1, 1'b0, 1'b0);
      chk_prot(6'h0A);
      api(op_del_pw, 2'h2, 32'hC000_0033, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_prot(6'h0A);
      do_reset();
      chk_prot(6'h1A);
      api(op_chg_prot, 2'h0, 32'h1234_5678, 1'b0, 1'b0, 1'b1, 1'b1);
      chk_prot(6'h1A);
      do_reset();
      chk_prot(6'h00);
      api(op_set_pw, 2'h1, 32'h4000_0055, 1'b0, 1'b0, 1'b0, 1'b0);
      api(op_del_pw, 2'h1, 32'h0000_0055, 1'b0, 1'b0, 1'b1, 1'b1);
      do_reset();
      chk_prot(6'h00);
      test_done();
   end
endmodule
`default_nettype wire
